// ==== ics_pkg.sv ====
package ics_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int FS_BPS = 400_000;
  localparam int HS_BPS = 3_400_000;
  // Quarter bit periods in clock cycles, rounded up
  localparam int QTR_FS = (CLK_HZ + 4 * FS_BPS - 1) / (4 * FS_BPS);
  localparam int QTR_HS = (CLK_HZ + 4 * HS_BPS - 1) / (4 * HS_BPS);
  localparam int FILT_LEN = 2;
  // ==========================================================
  // Bus addressing
  localparam logic [6:0] DEV_ADDR = 7'h75;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [7:0] HS_CODE = 8'h08;
  // ==========================================================
  // Device register map
  localparam logic [7:0] REG_GENERAL = 8'h01;
  localparam logic [7:0] REG_LOW = 8'h02;
  localparam logic [7:0] REG_HIGH = 8'h03;
  localparam logic [7:0] REG_ILIM = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h05;
  localparam logic [7:0] REG_NVM_CTRL = 8'hFF;
  localparam logic [7:0] NVM_CTRL_RESET = 8'h00;
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam int CTRL_SEL_BIT = 0;
  localparam int CTRL_WP_BIT = 5;
  localparam logic [1:0] SAVE_CODE = 2'h3;
  localparam logic [7:0] NVM_DEF_GENERAL = 8'h01;
  localparam logic [7:0] NVM_DEF_LOW = 8'h06;
  localparam logic [7:0] NVM_DEF_HIGH = 8'h00;
  localparam logic [7:0] NVM_DEF_ILIM = 8'h00;
  // ==========================================================
  // Host command registers
  localparam logic [3:0] HA_CMD = 4'h0;
  localparam logic [3:0] HA_STAT = 4'h4;
  localparam logic [3:0] HA_QDIV = 4'h8;
  localparam int CMD_RD_BIT = 16;
  localparam int CMD_HS_BIT = 17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Factory content of the store, slot 0 is register 01h
  function automatic logic [7:0] nvm_def(input logic [1:0] idx);
    case (idx)
      2'h0: nvm_def = NVM_DEF_GENERAL;
      2'h1: nvm_def = NVM_DEF_LOW;
      2'h2: nvm_def = NVM_DEF_HIGH;
      default: nvm_def = NVM_DEF_ILIM;
    endcase
  endfunction
endpackage

// ==== ics_link.sv ====
`timescale 1ns/1ns
// Open-drain wires: a line is low while any enabled driver pulls it low
interface ics_link;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input sda, output host_scl_o, output host_scl_oe, output host_sda_o,
    output host_sda_oe);
endinterface

// ==== ics_dev.sv ====
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
module ics_dev
  import ics_pkg::*;
#(
  parameter int FILT = FILT_LEN
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  ics_link.dev link,
  input wire logic [7:0] status_in,
  output logic [7:0] general_settings,
  output logic [7:0] low_switch_threshold,
  output logic [7:0] high_switch_threshold,
  output logic [7:0] input_current_limit,
  output logic high_speed_operation,
  output logic nvm_locked
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_RX = 3'b011,
    ST_WACK = 3'b100,
    ST_TX = 3'b101,
    ST_MACK = 3'b110
  } ics_dev_st_t;

  // True for the four configuration registers
  function automatic logic cfg_hit(input logic [7:0] p);
    cfg_hit = (p >= REG_GENERAL) && (p <= REG_ILIM);
  endfunction

  // Slot of a configuration register in the arrays
  function automatic logic [1:0] cfg_idx(input logic [7:0] p);
    cfg_idx = 2'(p[2:0] - 3'h1);
  endfunction

  logic [1:0] raw;
  logic [1:0] filt;
  logic [1:0] prev;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  ics_dev_st_t state;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic rw;
  logic got_ptr;
  logic sda_drive;
  logic [7:0] ptr;
  logic [7:0] ctrl;
  logic save_pend;
  logic load_pend;
  logic [7:0] work [0:3];
  logic [7:0] nvm [0:3];
  logic [7:0] rd_byte;
  logic commit;
  logic addr_end;

  // ==========================================================
  // Line conditioning
  assign raw = {link.sda, link.scl};

  // Two-stage synchroniser then a stability filter per line
  for (genvar i = 0; i < 2; i++)
  begin : g_line
    logic s1;
    logic s2;
    logic f;
    logic [3:0] cnt;
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        s1 <= 1'b1;
        s2 <= 1'b1;
        f <= 1'b1;
        cnt <= 4'h0;
      end
      else if (ce)
      begin
        s1 <= raw[i];
        s2 <= s1;
        if (s2 == f)
          cnt <= 4'h0;
        else if (cnt == 4'(FILT - 1))
        begin
          f <= s2;
          cnt <= 4'h0;
        end
        else
          cnt <= cnt + 4'h1;
      end
    end
    assign filt[i] = f;
  end

  // Previous filtered levels for edge detection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prev <= 2'b11;
    else if (ce)
      prev <= filt;
  end

  // Bit 0 is SCL, bit 1 is SDA
  assign scl_rise = filt[0] & ~prev[0];
  assign scl_fall = ~filt[0] & prev[0];
  assign start_det = filt[0] & prev[0] & prev[1] & ~filt[1];
  assign stop_det = filt[0] & prev[0] & ~prev[1] & filt[1];
  assign addr_end = (state == ST_ADDR) && scl_fall && (bitcnt == 4'h8);

  // ==========================================================
  // Protocol engine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ST_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      rw <= 1'b0;
      got_ptr <= 1'b0;
      sda_drive <= 1'b0;
    end
    else if (ce)
    begin
      if (start_det)
      begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        got_ptr <= 1'b0;
        sda_drive <= 1'b0;
      end
      else if (stop_det)
      begin
        state <= ST_IDLE;
        sda_drive <= 1'b0;
      end
      else
      begin
        case (state)
          ST_IDLE:
            sda_drive <= 1'b0;
          ST_ADDR, ST_RX:
          begin
            if (scl_rise)
            begin
              shreg <= {shreg[6:0], filt[1]};
              bitcnt <= bitcnt + 4'h1;
            end
            else if (scl_fall && bitcnt == 4'h8)
            begin
              if (state == ST_RX)
              begin
                sda_drive <= 1'b1;
                state <= ST_WACK;
              end
              else if (shreg[7:1] == DEV_ADDR)
              begin
                sda_drive <= 1'b1;
                rw <= shreg[0];
                state <= ST_AACK;
              end
              else
                state <= ST_IDLE;
            end
          end
          ST_AACK:
            if (scl_fall)
            begin
              bitcnt <= 4'h0;
              if (rw)
              begin
                shreg <= rd_byte;
                sda_drive <= ~rd_byte[7];
                state <= ST_TX;
              end
              else
              begin
                sda_drive <= 1'b0;
                state <= ST_RX;
              end
            end
          ST_WACK:
            if (scl_fall)
            begin
              sda_drive <= 1'b0;
              got_ptr <= 1'b1;
              bitcnt <= 4'h0;
              state <= ST_RX;
            end
          ST_TX:
            if (scl_rise)
              bitcnt <= bitcnt + 4'h1;
            else if (scl_fall)
            begin
              if (bitcnt == 4'h8)
              begin
                sda_drive <= 1'b0;
                state <= ST_MACK;
              end
              else
              begin
                sda_drive <= ~shreg[6];
                shreg <= {shreg[6:0], 1'b0};
              end
            end
          ST_MACK:
            if (scl_rise)
            begin
              rw <= ~filt[1];
              bitcnt <= 4'h9;
            end
            else if (scl_fall && bitcnt == 4'h9)
            begin
              bitcnt <= 4'h0;
              if (rw)
              begin
                shreg <= rd_byte;
                sda_drive <= ~rd_byte[7];
                state <= ST_TX;
              end
              else
                state <= ST_IDLE;
            end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // High-speed mode flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      high_speed_operation <= 1'b0;
    else if (ce)
    begin
      if (stop_det)
        high_speed_operation <= 1'b0;
      else if (addr_end && shreg[7:3] == HS_CODE_TOP)
        high_speed_operation <= 1'b1;
    end
  end

  // ==========================================================
  // Register file and store
  assign commit = ~start_det & ~stop_det & (state == ST_WACK) & scl_fall;

  // Pointer capture, writes, power-up load and save to store
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ptr <= 8'h00;
      ctrl <= NVM_CTRL_RESET;
      save_pend <= 1'b0;
      load_pend <= 1'b1;
      nvm_locked <= 1'b0;
      for (int k = 0; k < 4; k++)
      begin
        work[k] <= WORK_RESET;
        nvm[k] <= nvm_def(2'(k));
      end
    end
    else if (ce)
    begin
      if (load_pend)
      begin
        load_pend <= 1'b0;
        for (int k = 0; k < 4; k++)
          work[k] <= nvm[k];
      end
      else if (commit && !got_ptr)
        ptr <= shreg;
      else if (commit)
      begin
        if (cfg_hit(ptr) && !ctrl[CTRL_SEL_BIT])
          work[cfg_idx(ptr)] <= shreg;
        else if (cfg_hit(ptr) && !nvm_locked)
          nvm[cfg_idx(ptr)] <= shreg;
        else if (ptr == REG_NVM_CTRL)
        begin
          ctrl <= shreg;
          save_pend <= (shreg[7:6] == SAVE_CODE);
        end
      end
      if (stop_det && save_pend)
      begin
        save_pend <= 1'b0;
        if (!nvm_locked)
        begin
          for (int k = 0; k < 4; k++)
            nvm[k] <= work[k];
          nvm_locked <= ctrl[CTRL_WP_BIT];
        end
      end
    end
  end

  // Read data for the current pointer
  always_comb
  begin
    rd_byte = 8'h00;
    if (cfg_hit(ptr))
      rd_byte = ctrl[CTRL_SEL_BIT] ? nvm[cfg_idx(ptr)] : work[cfg_idx(ptr)];
    else if (ptr == REG_STATUS)
      rd_byte = status_in;
    else if (ptr == REG_NVM_CTRL)
      rd_byte = ctrl;
  end

  // ==========================================================
  // Outputs
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = sda_drive;
  assign general_settings = work[0];
  assign low_switch_threshold = work[1];
  assign high_switch_threshold = work[2];
  assign input_current_limit = work[3];
endmodule

// ==== ics_host.sv ====
`timescale 1ns/1ns
module ics_host
  import ics_pkg::*;
#(
  parameter int QTR_HS_CYC = QTR_HS
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  ics_link.host link,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  typedef enum logic [3:0] {
    P_INIT = 4'b0000,
    P_IDLE = 4'b0001,
    P_START = 4'b0010,
    P_MCODE = 4'b0011,
    P_RS_HS = 4'b0100,
    P_ADDRW = 4'b0101,
    P_PTR = 4'b0110,
    P_DATA = 4'b0111,
    P_RSTART = 4'b1000,
    P_ADDRR = 4'b1001,
    P_READ = 4'b1010,
    P_STOP = 4'b1011
  } ics_step_t;

  logic [7:0] cmd_ptr;
  logic [7:0] cmd_data;
  logic cmd_rd;
  logic cmd_hs;
  logic busy;
  logic go;
  logic nack;
  logic [7:0] rx_byte;
  logic [15:0] qdiv;
  logic wr_take;
  logic [1:0] sda_s;
  ics_step_t step;
  logic [1:0] q;
  logic [3:0] b;
  logic [15:0] tmr;
  logic [15:0] qlen;
  logic hs_now;
  logic tick;
  logic is_cond;
  logic [7:0] tx_byte;
  logic done;

  // ==========================================================
  // Register slave
  assign wr_take = awvalid & wvalid & ~bvalid;
  assign awready = wr_take;
  assign wready = wr_take;
  assign arready = ~rvalid;

  // Write channel: command launch and divider
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmd_ptr <= 8'h00;
      cmd_data <= 8'h00;
      cmd_rd <= 1'b0;
      cmd_hs <= 1'b0;
      qdiv <= 16'(QTR_FS);
      go <= 1'b0;
      busy <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (ce)
    begin
      go <= 1'b0;
      if (done)
        busy <= 1'b0;
      if (bvalid && bready)
        bvalid <= 1'b0;
      if (wr_take)
      begin
        bvalid <= 1'b1;
        bresp <= RESP_OKAY;
        if (awaddr == HA_CMD && !busy)
        begin
          cmd_ptr <= wdata[7:0];
          cmd_data <= wdata[15:8];
          cmd_rd <= wdata[CMD_RD_BIT];
          cmd_hs <= wdata[CMD_HS_BIT];
          go <= 1'b1;
          busy <= 1'b1;
        end
        else if (awaddr == HA_QDIV)
        begin
          if (wstrb[0])
            qdiv[7:0] <= wdata[7:0];
          if (wstrb[1])
            qdiv[15:8] <= wdata[15:8];
        end
        else if (awaddr != HA_STAT)
          bresp <= RESP_SLVERR;
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (rvalid && rready)
        rvalid <= 1'b0;
      else if (arvalid && !rvalid)
      begin
        rvalid <= 1'b1;
        rresp <= RESP_OKAY;
        case (araddr)
          HA_CMD: rdata <= {14'h0, cmd_hs, cmd_rd, cmd_data, cmd_ptr};
          HA_STAT: rdata <= {16'h0, rx_byte, 6'h0, nack, busy};
          HA_QDIV: rdata <= {16'h0, qdiv};
          default:
          begin
            rdata <= 32'h0;
            rresp <= RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Bus engine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sda_s <= 2'b11;
    else if (ce)
      sda_s <= {sda_s[0], link.sda};
  end

  // Master code and its repeated start go at the slower rate
  assign qlen = hs_now ? 16'(QTR_HS_CYC) : qdiv;
  assign tick = (step != P_IDLE) && (tmr >= qlen - 16'h1);
  assign is_cond = (step == P_INIT) || (step == P_START) || (step == P_RS_HS) ||
    (step == P_RSTART) || (step == P_STOP);
  // The power-up STOP also ends the busy time, so commands are accepted afterwards
  assign done = tick && (step == P_STOP || step == P_INIT) && (q == 2'h3);

  // Byte sent in each byte step
  always_comb
  begin
    case (step)
      P_MCODE: tx_byte = HS_CODE;
      P_ADDRW: tx_byte = {DEV_ADDR, 1'b0};
      P_PTR: tx_byte = cmd_ptr;
      P_DATA: tx_byte = cmd_data;
      P_ADDRR: tx_byte = {DEV_ADDR, 1'b1};
      default: tx_byte = 8'hFF;
    endcase
  end

  // Quarter-period sequencer for conditions and bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      step <= P_INIT;
      q <= 2'h0;
      b <= 4'h0;
      tmr <= 16'h0;
      hs_now <= 1'b0;
      nack <= 1'b0;
      rx_byte <= 8'h00;
      link.host_scl_oe <= 1'b0;
      link.host_sda_oe <= 1'b0;
    end
    else if (ce)
    begin
      tmr <= tick ? 16'h0 : tmr + 16'h1;
      if (step == P_IDLE)
      begin
        tmr <= 16'h0;
        if (go)
        begin
          nack <= 1'b0;
          step <= cmd_hs ? P_START : P_RSTART;
        end
      end
      else if (tick)
      begin
        q <= q + 2'h1;
        if (is_cond && step != P_INIT && step != P_STOP)
        begin
          case (q)
            2'h0: link.host_sda_oe <= 1'b0;
            2'h1: link.host_scl_oe <= 1'b0;
            2'h2: link.host_sda_oe <= 1'b1;
            default:
            begin
              link.host_scl_oe <= 1'b1;
              if (step == P_START)
                step <= P_MCODE;
              else if (step == P_RS_HS)
              begin
                hs_now <= 1'b1;
                step <= P_ADDRW;
              end
              else
                step <= (b == 4'h0) ? P_ADDRW : P_ADDRR;
              b <= 4'h0;
            end
          endcase
        end
        else if (is_cond)
        begin
          case (q)
            2'h0: link.host_sda_oe <= 1'b1;
            2'h1: link.host_scl_oe <= 1'b0;
            2'h2: link.host_sda_oe <= 1'b0;
            default:
            begin
              hs_now <= 1'b0;
              step <= P_IDLE;
            end
          endcase
        end
        else
        begin
          case (q)
            2'h0: link.host_sda_oe <= (step != P_READ) && (b < 4'h8) && !tx_byte[3'(7 - b)];
            2'h1: link.host_scl_oe <= 1'b0;
            2'h2:
              if (b < 4'h8)
                rx_byte <= (step == P_READ) ? {rx_byte[6:0], sda_s[1]} : rx_byte;
              else if (sda_s[1] && step != P_READ && step != P_MCODE)
                nack <= 1'b1;
            default:
            begin
              link.host_scl_oe <= 1'b1;
              b <= b + 4'h1;
              if (b == 4'h8)
              begin
                b <= 4'h0;
                if (nack)
                  step <= P_STOP;
                else
                begin
                  case (step)
                    P_MCODE: step <= P_RS_HS;
                    P_ADDRW: step <= P_PTR;
                    P_PTR: step <= cmd_rd ? P_RSTART : P_DATA;
                    P_ADDRR: step <= P_READ;
                    default: step <= P_STOP;
                  endcase
                  if (step == P_PTR && cmd_rd)
                    b <= 4'h1;
                end
              end
            end
          endcase
        end
      end
    end
  end

  assign link.host_scl_o = 1'b0;
  assign link.host_sda_o = 1'b0;
endmodule

// ==== ics_chk.sv ====
`timescale 1ns/1ns
module ics_chk
  import ics_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic first_b;
  logic wr_m;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic start_c;
  logic stop_c;
  logic rise_c;
  // Line events seen on the raw wires
  assign start_c = scl & scl_q & sda_q & ~sda;
  assign stop_c = scl & scl_q & ~sda_q & sda;
  assign rise_c = scl & ~scl_q;
  // Previous line levels
  always_ff @(posedge aclk)
  begin
    scl_q <= scl;
    sda_q <= sda;
  end
  // Bit count within a byte and capture of the address byte
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt <= 4'h0;
      first_b <= 1'b0;
      wr_m <= 1'b0;
      sh <= 8'h00;
    end
    else if (start_c || stop_c)
    begin
      cnt <= 4'h0;
      first_b <= start_c;
      wr_m <= 1'b0;
    end
    else if (rise_c)
    begin
      sh <= {sh[6:0], sda};
      cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      if (cnt == 4'h8)
        first_b <= 1'b0;
      if (cnt == 4'h8 && first_b)
        wr_m <= (sh[7:1] == DEV_ADDR) && !sh[0];
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence released8;
    !dev_sda_oe [*8];
  endsequence
  AST_OD_LEVEL: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drives sda high");
  AST_HOST_SCL_OD: assert property (host_scl_oe |-> !host_scl_o)
    else $error("host drives scl high");
  AST_HOST_SDA_OD: assert property (host_sda_oe |-> !host_sda_o)
    else $error("host drives sda high");
  AST_ACK_STEADY: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device sda changed while scl high");
  AST_OE_SCL_LOW: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device sda switched with scl high");
  AST_ADDR_ACK: assert property (rise_c && cnt == 4'h8 && first_b |->
    dev_sda_oe == (sh[7:1] == DEV_ADDR))
    else $error("address acknowledge wrong");
  AST_WR_ACK: assert property (rise_c && cnt == 4'h8 && !first_b && wr_m |-> dev_sda_oe)
    else $error("write byte not acknowledged");
  AST_STOP_IDLE: assert property (stop_c |-> ##1 released8)
    else $error("device drives after stop");
  AST_START_IDLE: assert property (start_c |-> ##1 released8)
    else $error("device drives after start");
  AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl [*4])
    else $error("scl high phase too short");
endmodule

// ==== ics_tb.sv ====
`timescale 1ns/1ns
module ics_tb
  import ics_pkg::*;
;
  logic aclk;
  logic aresetn;
  logic [7:0] status_in;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [7:0] wk [4];
  logic hs_op, locked;
  logic hs_seen = 1'b0;
  logic [7:0] fdef [4] = '{NVM_DEF_GENERAL, NVM_DEF_LOW, NVM_DEF_HIGH, NVM_DEF_ILIM};
  logic [7:0] wv [4] = '{8'h5B, 8'h1D, 8'h9E, 8'h27};
  int mismatches, checked;
  ics_link ics_link_i ();
  ics_dev ics_dev_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .link(ics_link_i.dev),
    .status_in(status_in), .general_settings(wk[0]), .low_switch_threshold(wk[1]),
    .high_switch_threshold(wk[2]), .input_current_limit(wk[3]),
    .high_speed_operation(hs_op), .nvm_locked(locked));
  ics_host ics_host_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .link(ics_link_i.host),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(1'b1));
  ics_chk ics_chk_i (.aclk(aclk), .aresetn(aresetn), .host_scl_o(ics_link_i.host_scl_o),
    .host_scl_oe(ics_link_i.host_scl_oe), .host_sda_o(ics_link_i.host_sda_o),
    .host_sda_oe(ics_link_i.host_sda_oe), .dev_sda_o(ics_link_i.dev_sda_o),
    .dev_sda_oe(ics_link_i.dev_sda_oe), .scl(ics_link_i.scl), .sda(ics_link_i.sda));
  // Clock
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Remembers that the device entered high speed at least once
  always @(posedge aclk)
    if (hs_op === 1'b1)
      hs_seen <= 1'b1;
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Register bus write, each channel released when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        rs = bresp;
        break;
      end
    end
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        v = rdata;
        rs = rresp;
        break;
      end
    end
  endtask
  // Poll status until the link is idle
  task automatic wait_idle(output logic [15:0] st);
    logic [31:0] v;
    logic [1:0] rs;
    st = 16'h0001;
    while (st[0])
    begin
      axi_rd(HA_STAT, v, rs);
      st = v[15:0];
    end
  endtask
  task automatic reg_wr(input logic [7:0] p, input logic [7:0] v, input logic h);
    logic [15:0] st;
    logic [1:0] rs;
    axi_wr(HA_CMD, {14'h0, h, 1'b0, v, p}, rs);
    chk("cmd resp", RESP_OKAY, rs);
    wait_idle(st);
  endtask
  task automatic reg_rd(input logic [7:0] p, input logic h, input logic [7:0] exp);
    logic [15:0] st;
    logic [1:0] rs;
    axi_wr(HA_CMD, {14'h0, h, 1'b1, 8'h00, p}, rs);
    wait_idle(st);
    chk("read nack", 1'b0, st[1]);
    chk("read byte", exp, st[15:8]);
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (90000) @(posedge aclk);
    mismatches++;
    conclude();
  end
  // Main sequence
  initial
  begin
    logic [15:0] st;
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    status_in = 8'h5A;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_wr(HA_CMD, 32'h0, r);
    chk("busy cmd", RESP_SLVERR, r);
    axi_wr(4'hC, 32'h0, r);
    chk("unmapped wr", RESP_SLVERR, r);
    axi_rd(4'hC, d, r);
    chk("unmapped rd", {30'h0, RESP_SLVERR}, {d[29:0], r});
    axi_rd(HA_QDIV, d, r);
    chk("qdiv reset", 32'(QTR_FS), d[15:0]);
    axi_wr(HA_QDIV, 32'h8, r);
    wait_idle(st);
    for (int i = 0; i < 4; i++)
    begin
      chk("loaded reg", fdef[i], wk[i]);
      reg_rd(8'(i + 1), 1'b0, fdef[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      reg_wr(8'(i + 1), wv[i], i[0]);
      chk("work reg", wv[i], wk[i]);
      reg_rd(8'(i + 1), !i[0], wv[i]);
      chk("hs after stop", 1'b0, hs_op);
    end
    chk("hs entered", 1'b1, hs_seen);
    reg_wr(REG_STATUS, 8'hFF, 1'b0);
    reg_rd(REG_STATUS, 1'b0, 8'h5A);
    status_in <= 8'hA5;
    reg_rd(REG_STATUS, 1'b1, 8'hA5);
    reg_rd(8'h06, 1'b0, 8'h00);
    reg_rd(8'h07, 1'b1, 8'h00);
    reg_rd(REG_NVM_CTRL, 1'b0, NVM_CTRL_RESET);
    reg_wr(REG_NVM_CTRL, 8'hC0, 1'b0);
    reg_wr(REG_NVM_CTRL, 8'h01, 1'b0);
    for (int i = 0; i < 4; i++)
      reg_rd(8'(i + 1), 1'b0, wv[i]);
    reg_wr(REG_GENERAL, 8'h33, 1'b0);
    reg_rd(REG_GENERAL, 1'b0, 8'h33);
    chk("work kept", wv[0], wk[0]);
    reg_wr(REG_NVM_CTRL, 8'h00, 1'b0);
    reg_rd(REG_GENERAL, 1'b0, wv[0]);
    reg_wr(REG_NVM_CTRL, 8'hE0, 1'b0);
    chk("locked", 1'b1, locked);
    reg_wr(REG_NVM_CTRL, 8'h01, 1'b0);
    reg_wr(REG_GENERAL, 8'h44, 1'b0);
    reg_rd(REG_GENERAL, 1'b0, wv[0]);
    conclude();
  end
endmodule
